// ===== inc/aer_pkg.sv
// Purpose: shared constants and carriers for the error mask, control and header log bank
// Assumes: configuration accesses arrive one word at a time on the port core clock
// Notes:   offsets are byte addresses inside extended configuration space

`default_nettype none

package aer_pkg;

  // ****************************************
  // widths and offsets
  // ****************************************
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          HDR_WORDS      = 4;
  localparam int          FIRST_ERR_W    = 5;
  localparam logic [11:0] OFF_COR_STATUS = 12'h110;
  localparam logic [11:0] OFF_COR_MASK   = 12'h114;
  localparam logic [11:0] OFF_ERR_CTRL   = 12'h118;
  localparam logic [11:0] OFF_HDR_LOG0   = 12'h11C;
  localparam logic [11:0] HDR_STRIDE     = 12'h004;

  // ****************************************
  // reset values and implemented bits
  // ****************************************
  localparam logic [31:0] RST_COR_MASK   = 32'h0000_2000;
  localparam logic [31:0] RST_COR_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_ERR_CTRL   = 32'h0000_00A0;
  localparam logic [31:0] RST_HDR_LOG    = 32'h0000_0000;
  localparam logic [31:0] COR_IMPL       = 32'h0000_31C1;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ADV_NF_BIT       = 13;
  localparam int RETRY_TIMER_BIT  = 12;
  localparam int RETRY_ROLL_BIT   = 8;
  localparam int LINK_PKT_BIT     = 7;
  localparam int TRANS_PKT_BIT    = 6;
  localparam int RX_ERR_BIT       = 0;
  localparam int CHECK_EN_BIT     = 8;
  localparam int CHECK_SUP_BIT    = 7;
  localparam int GEN_EN_BIT       = 6;
  localparam int GEN_SUP_BIT      = 5;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        be;
  } aer_cfg_req_s;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } aer_cfg_rsp_s;

  typedef struct packed {
    logic                      valid;
    logic [FIRST_ERR_W-1:0]    bit_pos;
    logic [HDR_WORDS-1:0][31:0] hdr;
  } aer_unc_evt_s;

endpackage : aer_pkg

`default_nettype wire

// ===== src/aer_mask_control_header_log.sv
// Purpose: correctable error mask, error capability/control and header log registers
// Assumes: all inputs come from logic on core_clk; uncorrectable status lives outside
// Notes:   correctable status at 110h is kept here since the masks gate its messages
//
// Behaviour
// - masked correctable error still sets status, is not logged, sends no message
// - mask register resets to 0000 2000h with advisory nonfatal mask set
// - bit 12 masks retry timer expiry, bit 8 masks retry count rollover
// - bits 7, 6 and 0 mask link packet, transaction packet and receiver errors
// - reserved mask bits read zero and ignore writes
// - control bit 8 is read/write end crc check enable
// - control bit 7 is read-only one, check supported
// - control bit 6 is read/write end crc generate enable
// - control bit 5 is read-only one, generate supported
// - control bits 4:0 hold status position of first uncorrectable error
// - control register resets to 0000 00A0h, bits 31:9 read zero
// - error capture loads header log with the offending packet header
// - header words sit at 11Ch, 120h, 124h and 128h
// - header log is read-only and resets to zero
// - correctable status bits clear only on a written one

`timescale 1ns/1ps
`default_nettype none

module aer_mask_control_header_log (
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire aer_pkg::aer_cfg_req_s cfg_req,
  output var  aer_pkg::aer_cfg_rsp_s cfg_rsp,
  input  wire logic [31:0]          cor_evt,
  input  wire aer_pkg::aer_unc_evt_s unc_evt,
  input  wire logic [31:0]          unc_status,
  output logic                      cor_msg,
  output logic                      end_crc_check_enable,
  output logic                      end_crc_generate_enable
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0]                           cor_mask;
    logic [31:0]                           cor_status;
    logic                                  check_en;
    logic                                  gen_en;
    logic [aer_pkg::FIRST_ERR_W-1:0]       first_err;
    logic                                  log_held;
    logic [aer_pkg::HDR_WORDS-1:0][31:0]   hdr_log;
    logic                                  msg;
    aer_pkg::aer_cfg_rsp_s                 rsp;
  } aer_state_s;

  aer_state_s                     st;
  aer_state_s                     next_st;
  logic [11:0]                    word_addr;
  logic [31:0]                    lane_mask;
  logic [31:0]                    evt;
  logic [31:0]                    clr;
  logic [aer_pkg::HDR_WORDS-1:0]  hdr_hit;
  logic                           release_log;
  logic                           capture;
  logic                           unmasked_hit;
  logic [31:0]                    cor_mask_q;

  // ****************************************
  // address decode
  // ****************************************
  // low address bits are ignored so that any byte address lands on its word
  assign word_addr = {cfg_req.addr[11:2], 2'b00};
  assign lane_mask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}},
                      {8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}};

  // one hit line per header word, consecutive words one stride apart
  genvar g;
  generate
    for (g = 0; g < aer_pkg::HDR_WORDS; g++) begin : g_hdr_hit
      assign hdr_hit[g] = (word_addr == 12'(aer_pkg::OFF_HDR_LOG0
                                            + 12'(g) * aer_pkg::HDR_STRIDE));
    end
  endgenerate

  // ****************************************
  // event qualification
  // ****************************************
  // only implemented status positions can ever be set
  assign evt = cor_evt & aer_pkg::COR_IMPL;
  // any implemented event whose mask bit is clear asks for a message
  assign unmasked_hit = |(evt & ~st.cor_mask);
  // a write of one clears; a write of zero leaves the bit alone
  assign clr = (cfg_req.wr && word_addr == aer_pkg::OFF_COR_STATUS)
               ? (cfg_req.wdata & lane_mask) : 32'h0000_0000;
  // log frees up once software clears the status bit the pointer names
  assign release_log = st.log_held && !unc_status[st.first_err];
  // a capture in the release cycle is taken so that event is not lost
  assign capture = unc_evt.valid && (!st.log_held || release_log);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st         = st;
    next_st.rsp.ack = 1'b0;

    // set wins over clear so an event in the clearing cycle survives
    next_st.cor_status = (st.cor_status & ~clr) | evt;

    // masked events only touch status; an unmasked one raises a message
    next_st.msg = unmasked_hit;

    // mask writes reach implemented bits only, so reserved bits stay zero
    if (cfg_req.wr && word_addr == aer_pkg::OFF_COR_MASK) begin
      next_st.cor_mask = (st.cor_mask & ~(lane_mask & aer_pkg::COR_IMPL))
                         | (cfg_req.wdata & lane_mask & aer_pkg::COR_IMPL);
    end

    // control register: two enables writable, the rest fixed or hardware
    if (cfg_req.wr && word_addr == aer_pkg::OFF_ERR_CTRL) begin
      if (cfg_req.be[1]) begin
        next_st.check_en = cfg_req.wdata[aer_pkg::CHECK_EN_BIT];
      end
      if (cfg_req.be[0]) begin
        next_st.gen_en = cfg_req.wdata[aer_pkg::GEN_EN_BIT];
      end
    end

    // header log and first error pointer: writes never reach them
    if (release_log) begin
      next_st.log_held = 1'b0;
    end
    if (capture) begin
      next_st.log_held  = 1'b1;
      next_st.first_err = unc_evt.bit_pos;
      next_st.hdr_log   = unc_evt.hdr;
    end

    // read path; unmapped words inside the window answer zero
    if (cfg_req.rd || cfg_req.wr) begin
      next_st.rsp.ack = 1'b1;
    end
    if (cfg_req.rd) begin
      next_st.rsp.rdata = 32'h0000_0000;
      unique case (word_addr)
        aer_pkg::OFF_COR_STATUS: next_st.rsp.rdata = st.cor_status;
        aer_pkg::OFF_COR_MASK:   next_st.rsp.rdata = st.cor_mask;
        aer_pkg::OFF_ERR_CTRL: begin
          // upper bits fall through as zero
          next_st.rsp.rdata[aer_pkg::CHECK_EN_BIT]  = st.check_en;
          next_st.rsp.rdata[aer_pkg::CHECK_SUP_BIT] = 1'b1;
          next_st.rsp.rdata[aer_pkg::GEN_EN_BIT]    = st.gen_en;
          next_st.rsp.rdata[aer_pkg::GEN_SUP_BIT]   = 1'b1;
          next_st.rsp.rdata[aer_pkg::FIRST_ERR_W-1:0] = st.first_err;
        end
        default: begin
          for (int i = 0; i < aer_pkg::HDR_WORDS; i++) begin
            if (hdr_hit[i]) begin
              next_st.rsp.rdata = st.hdr_log[i];
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // reset values chosen so the control word reads back its fixed pattern
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st.cor_mask   <= aer_pkg::RST_COR_MASK;
      st.cor_status <= aer_pkg::RST_COR_STATUS;
      st.check_en   <= aer_pkg::RST_ERR_CTRL[aer_pkg::CHECK_EN_BIT];
      st.gen_en     <= aer_pkg::RST_ERR_CTRL[aer_pkg::GEN_EN_BIT];
      st.first_err  <= aer_pkg::RST_ERR_CTRL[aer_pkg::FIRST_ERR_W-1:0];
      st.log_held   <= 1'b0;
      st.hdr_log    <= {aer_pkg::HDR_WORDS{aer_pkg::RST_HDR_LOG}};
      st.msg        <= 1'b0;
      st.rsp        <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign cfg_rsp                 = st.rsp;
  assign cor_msg                 = st.msg;
  assign end_crc_check_enable    = st.check_en;
  assign end_crc_generate_enable = st.gen_en;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_ctrl_read;
    cfg_req.rd && word_addr == aer_pkg::OFF_ERR_CTRL;
  endsequence

  sequence s_ctrl_answer;
    cfg_rsp.ack && cfg_rsp.rdata[7] && cfg_rsp.rdata[5] && cfg_rsp.rdata[31:9] == 23'h0;
  endsequence

  property p_masked_quiet;
    ((cor_evt & aer_pkg::COR_IMPL & cor_mask_q) != 32'h0
      && (cor_evt & aer_pkg::COR_IMPL & ~cor_mask_q) == 32'h0) |=> !cor_msg;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked correctable error raised a message");

  property p_status_set;
    (evt != 32'h0) |=> ((st.cor_status & $past(evt)) == $past(evt));
  endproperty
  a_status_set: assert property (p_status_set)
    else $error("correctable event did not set its status bit");

  property p_unmasked_msg;
    unmasked_hit |=> cor_msg ##1 (!cor_msg || $past(unmasked_hit));
  endproperty
  a_unmasked_msg: assert property (p_unmasked_msg)
    else $error("unmasked correctable error gave no single message");

  property p_mask_reserved;
    (st.cor_mask & ~aer_pkg::COR_IMPL) == 32'h0;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("reserved mask bit became set");

  property p_ctrl_read;
    s_ctrl_read |=> s_ctrl_answer;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read returned wrong fixed bits");

  property p_capture;
    (unc_evt.valid && !st.log_held) |=>
      (st.hdr_log == $past(unc_evt.hdr)) && (st.first_err == $past(unc_evt.bit_pos));
  endproperty
  a_capture: assert property (p_capture)
    else $error("header log did not capture the packet header");

  property p_frozen;
    (st.log_held && unc_status[st.first_err]) |=>
      $stable(st.hdr_log) && $stable(st.first_err);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("header log changed while its status was set");

  property p_w1c;
    (evt == 32'h0) |=> (st.cor_status == ($past(st.cor_status) & ~$past(clr)));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status changed other than by a written one");

  property p_check_en;
    (cfg_req.wr && word_addr == aer_pkg::OFF_ERR_CTRL && cfg_req.be[1]) |=>
      end_crc_check_enable == $past(cfg_req.wdata[8]);
  endproperty
  a_check_en: assert property (p_check_en)
    else $error("check enable did not follow the write");

  // helper copy of the mask for the quiet check
  assign cor_mask_q = st.cor_mask;

endmodule : aer_mask_control_header_log

`default_nettype wire

// ===== tb/aer_root_model.sv
// Purpose: upstream side that receives correctable error messages from the port
// Assumes: each message arrives as a one-cycle pulse on cor_msg
// Notes:   only counts messages; the bench compares counts before and after events

`timescale 1ns/1ps
`default_nettype none

module aer_root_model (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic cor_msg,
  output var  int   msg_count
);
  // one message per high cycle; a level stuck high would inflate the count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      msg_count <= 0;
    end else if (cor_msg === 1'b1) begin
      msg_count <= msg_count + 1;
    end
  end
endmodule : aer_root_model

`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench for the error mask, control and header log bank
// Assumes: one access per request pulse, ack one cycle later
// Notes:   uncorrectable status is modelled by the bench on unc_status

`timescale 1ns/1ps
`default_nettype none

module tb;
  // ****************************************
  // signals and instances
  // ****************************************
  logic                  core_clk   = 1'b0;
  logic                  resetn     = 1'b0;
  aer_pkg::aer_cfg_req_s cfg_req    = '0;
  aer_pkg::aer_cfg_rsp_s cfg_rsp;
  logic [31:0]           cor_evt    = '0;
  aer_pkg::aer_unc_evt_s unc_evt    = '0;
  logic [31:0]           unc_status = '0;
  logic                  cor_msg;
  logic                  chk_en;
  logic                  gen_en;
  int                    msg_count;
  int                    fail_count = 0;
  int                    checks     = 0;
  logic [31:0]           rd_val;

  aer_mask_control_header_log DUT (
    .core_clk(core_clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .cor_evt(cor_evt), .unc_evt(unc_evt), .unc_status(unc_status), .cor_msg(cor_msg),
    .end_crc_check_enable(chk_en), .end_crc_generate_enable(gen_en));

  aer_root_model root (.core_clk(core_clk), .resetn(resetn), .cor_msg(cor_msg),
    .msg_count(msg_count));

  // 40 MHz
  always #12.5 core_clk = ~core_clk;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // request is a one-cycle pulse; ack and rdata are read at the rising edge after
  // the taking edge, before that edge's update lands, so no race with the bank
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge core_clk);
    cfg_req.rd    <= ~wr;
    cfg_req.wr    <= wr;
    cfg_req.addr  <= addr;
    cfg_req.wdata <= wdata;
    cfg_req.be    <= 4'hF;
    @(posedge core_clk);
    cfg_req.rd <= 1'b0;
    cfg_req.wr <= 1'b0;
    @(posedge core_clk);
    while (cfg_rsp.ack !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    check("ack", {31'h0, cfg_rsp.ack}, 32'h1);
    rd_val = cfg_rsp.rdata;
  endtask : access

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input string name);
    access(1'b0, addr, 32'h0);
    check(name, rd_val, exp);
  endtask : rd_chk

  task automatic pulse_cor(input logic [31:0] bits);
    @(posedge core_clk);
    cor_evt <= bits;
    @(posedge core_clk);
    cor_evt <= '0;
    repeat (3) @(posedge core_clk);
  endtask : pulse_cor

  task automatic pulse_unc(input logic [4:0] pos, input logic [31:0] base);
    @(posedge core_clk);
    unc_evt.valid   <= 1'b1;
    unc_evt.bit_pos <= pos;
    for (int i = 0; i < 4; i++) begin
      unc_evt.hdr[i] <= base + 32'(i);
    end
    @(posedge core_clk);
    unc_evt.valid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse_unc

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values;
    rd_chk(aer_pkg::OFF_COR_MASK, 32'h0000_2000, "mask reset");
    rd_chk(aer_pkg::OFF_ERR_CTRL, 32'h0000_00A0, "ctrl reset");
    for (int i = 0; i < 4; i++) begin
      rd_chk(12'h11C + 12'(4 * i), 32'h0, "hdr reset");
    end
  endtask : t_reset_values

  task automatic t_mask_access;
    access(1'b1, aer_pkg::OFF_COR_MASK, 32'hFFFF_FFFF);
    rd_chk(aer_pkg::OFF_COR_MASK, 32'h0000_31C1, "mask ones");
    access(1'b1, aer_pkg::OFF_COR_MASK, 32'h0000_0000);
    rd_chk(aer_pkg::OFF_COR_MASK, 32'h0000_0000, "mask zero");
  endtask : t_mask_access

  // read-only capability bits must survive writes of zero
  task automatic t_control;
    access(1'b1, aer_pkg::OFF_ERR_CTRL, 32'hFFFF_FFFF);
    rd_chk(aer_pkg::OFF_ERR_CTRL, 32'h0000_01E0, "ctrl ones");
    check("check en", {31'h0, chk_en}, 32'h1);
    check("gen en", {31'h0, gen_en}, 32'h1);
    access(1'b1, aer_pkg::OFF_ERR_CTRL, 32'h0000_0000);
    rd_chk(aer_pkg::OFF_ERR_CTRL, 32'h0000_00A0, "ctrl zero");
    check("check off", {31'h0, chk_en}, 32'h0);
    check("gen off", {31'h0, gen_en}, 32'h0);
    access(1'b1, 12'h11C, 32'hFFFF_FFFF);
    rd_chk(12'h11C, 32'h0, "hdr write");
  endtask : t_control

  task automatic t_correctable;
    int base;
    access(1'b1, aer_pkg::OFF_COR_MASK, 32'h0000_1000);
    base = msg_count;
    pulse_cor(32'h0000_1000);
    check("masked msg", 32'(msg_count - base), 32'h0);
    pulse_cor(32'h0000_00C1);
    check("unmasked msg", 32'(msg_count - base), 32'h1);
    rd_chk(aer_pkg::OFF_COR_STATUS, 32'h0000_10C1, "status set");
    access(1'b1, aer_pkg::OFF_COR_STATUS, 32'h0);
    rd_chk(aer_pkg::OFF_COR_STATUS, 32'h0000_10C1, "w0 keeps");
    access(1'b1, aer_pkg::OFF_COR_STATUS, 32'h0000_1001);
    rd_chk(aer_pkg::OFF_COR_STATUS, 32'h0000_00C0, "w1 clears");
  endtask : t_correctable

  task automatic t_header_log;
    // the outside status bit rises a cycle before the error, so the first capture stays held
    @(posedge core_clk);
    unc_status <= 32'h0000_0010;
    pulse_unc(5'd4, 32'hA000_0000);
    rd_chk(aer_pkg::OFF_ERR_CTRL, 32'h0000_00A4, "first err");
    for (int i = 0; i < 4; i++) begin
      rd_chk(12'h11C + 12'(4 * i), 32'hA000_0000 + 32'(i), "hdr cap");
    end
    @(posedge core_clk);
    unc_status <= 32'h0000_0010;
    pulse_unc(5'd9, 32'hB000_0000);
    rd_chk(aer_pkg::OFF_ERR_CTRL, 32'h0000_00A4, "ptr held");
    rd_chk(12'h128, 32'hA000_0003, "hdr held");
    @(posedge core_clk);
    unc_status <= 32'h0;
    pulse_unc(5'd9, 32'hB000_0000);
    rd_chk(aer_pkg::OFF_ERR_CTRL, 32'h0000_00A9, "ptr new");
    rd_chk(12'h128, 32'hB000_0003, "hdr new");
  endtask : t_header_log

  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset_values();
    t_mask_access();
    t_control();
    t_correctable();
    t_header_log();
    conclude();
  end

  // whole run needs well under 1000 cycles; this cuts a hung handshake
  initial begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
endmodule : tb

`default_nettype wire
